// ---- axi_lite_if.sv ----
// Interface bundling the AXI4-Lite register channels.
`timescale 1ns/100ps
interface axi_lite_if;
    logic [7:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    modport slave(input awaddr, awvalid, wdata, wstrb, wvalid, bready,
        araddr, arvalid, rready, output awready, wready, bresp, bvalid,
        arready, rdata, rresp, rvalid);
    modport master(output awaddr, awvalid, wdata, wstrb, wvalid, bready,
        araddr, arvalid, rready, input awready, wready, bresp, bvalid,
        arready, rdata, rresp, rvalid);
endinterface

// ---- axi_lite_slave.sv ----
// AXI4-Lite slave turning bus transfers into register strobes.
`timescale 1ns/100ps
module axi_lite_slave (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Bus
    axi_lite_if.slave bus,
    // Register side
    output logic wrEn,
    output logic [7:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrOk,
    output logic [7:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdOk
);
    typedef struct packed {
        logic awHave;
        logic wHave;
        logic [7:0] aw;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bValid;
        logic bErr;
        logic rValid;
        logic rErr;
        logic [31:0] rd;
    } slv_t;
    slv_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (bus.awvalid && !s_q.awHave && !s_q.bValid) begin
            s_d.awHave = 1'b1;
            s_d.aw = bus.awaddr;
        end
        if (bus.wvalid && !s_q.wHave && !s_q.bValid) begin
            s_d.wHave = 1'b1;
            s_d.wd = bus.wdata;
            s_d.ws = bus.wstrb;
        end
        if (s_q.awHave && s_q.wHave) begin
            s_d.awHave = 1'b0;
            s_d.wHave = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bErr = !wrOk;
        end
        if (s_q.bValid && bus.bready) begin
            s_d.bValid = 1'b0;
        end
        if (bus.arvalid && !s_q.rValid) begin
            s_d.rValid = 1'b1;
            s_d.rErr = !rdOk;
            s_d.rd = rdOk ? rdData : 32'h00000000;
        end else if (s_q.rValid && bus.rready) begin
            s_d.rValid = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.awready = !s_q.awHave && !s_q.bValid;
    assign bus.wready = !s_q.wHave && !s_q.bValid;
    assign bus.bvalid = s_q.bValid;
    assign bus.bresp = s_q.bErr ? 2'h2 : 2'h0;
    assign bus.arready = !s_q.rValid;
    assign bus.rvalid = s_q.rValid;
    assign bus.rdata = s_q.rd;
    assign bus.rresp = s_q.rErr ? 2'h2 : 2'h0;
    assign wrEn = s_q.awHave && s_q.wHave;
    assign wrAddr = s_q.aw;
    assign wrData = s_q.wd;
    assign wrStrb = s_q.ws;
    assign rdAddr = bus.araddr;
endmodule

// ---- dram_ctl_model.sv ----
// Controller model driving gate, command and termination pins.
`timescale 1ns/100ps
module dram_ctl_model #(
    parameter int RESET_EXIT = 8,
    parameter int WRITE_GAP = 6,
    parameter int UPDATE_DELAY = 10
) (
    // Clock
    input wire logic mclk,
    // Pins toward the device, one rank only
    output logic runGate,
    output logic chipSelect_b,
    output logic actPin_b,
    output logic rasPin,
    output logic casPin,
    output logic wePin,
    output logic [1:0] groupSelectBits,
    output logic [1:0] bankSelectBits,
    output logic [17:0] addrPins,
    output logic dieTerminationControl,
    output logic connectivityTestSelect
);
    // ====
    // Idle levels
    initial begin
        runGate = 1'b0;
        connectivityTestSelect = 1'b0;
        dieTerminationControl = 1'b1;
        chipSelect_b = 1'b1;
        {actPin_b, rasPin, casPin, wePin} = 4'h5;
        {groupSelectBits, bankSelectBits, addrPins} = '0;
    end
    // ====
    // Commands
    // Once deselected, command and address pins are inverted; group and bank bits keep their values.
    task automatic issue(input logic [3:0] arcw, input logic [1:0] grp,
        input logic [1:0] bnk, input logic [17:0] adr);
        @(posedge mclk);
        chipSelect_b <= 1'b0;
        {actPin_b, rasPin, casPin, wePin} <= arcw;
        {groupSelectBits, bankSelectBits, addrPins} <= {grp, bnk, adr};
        @(posedge mclk);
        chipSelect_b <= 1'b1;
        {actPin_b, rasPin, casPin, wePin} <= ~arcw;
        addrPins <= ~adr;
    endtask
    task automatic power_up(input int initWait);
        logic [2:0] order[7] = '{3, 6, 5, 4, 2, 1, 0};
        repeat (initWait + 4) @(posedge mclk);
        runGate <= 1'b1;
        repeat (RESET_EXIT) @(posedge mclk);
        foreach (order[i]) begin
            issue(4'h8, {1'b0, order[i][2]}, order[i][1:0], 18'h0);
            repeat (order[i] == 0 ? UPDATE_DELAY : WRITE_GAP) @(posedge mclk);
        end
        issue(4'he, 2'h0, 2'h0, 18'h00400);
    endtask
    task automatic drop_gate();
        @(posedge mclk);
        runGate <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
endmodule

// ---- dram_init_pkg.sv ----
// Package of constants and types for the DRAM power-up init block.
package dram_init_pkg;
    // ========================================================
    // Register map (byte addresses)
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] MODE3_OFF = 8'h08;
    localparam logic [7:0] MODE4_OFF = 8'h0c;
    localparam logic [7:0] MODE5_OFF = 8'h10;
    localparam logic [7:0] LASTCMD_OFF = 8'h14;
    // ========================================================
    // Field positions
    localparam int GEAR_HALF_BIT = 3;
    localparam int PDA_BIT = 4;
    localparam int MAXPS_BIT = 1;
    localparam int CAL_LSB = 6;
    localparam int PARLAT_LSB = 0;
    localparam int CTRL_OTF_BIT = 0;
    localparam int CTRL_BC4_BIT = 1;
    localparam int CTRL_RESTART_BIT = 2;
    // ========================================================
    // Reset values of mode registers and the control register
    localparam logic [17:0] MODE3_RST = 18'h00008;
    localparam logic [17:0] MODE4_RST = 18'h00000;
    localparam logic [17:0] MODE5_RST = 18'h00000;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    // ========================================================
    // Timing
    localparam int CLK_PS = 5000;
    localparam int INIT_TIME_NS = 500000;
    localparam int INIT_CYCLES = (INIT_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;
    // ========================================================
    // Organization
    localparam int GROUPS = 4;
    localparam int BANKS = 4;
    localparam int ROW_BITS = 16;
    localparam int PREFETCH = 8;
    localparam int CHOP_BEATS = 4;
    // ========================================================
    // Command decode and sequencer states
    typedef enum logic [2:0] {
        CMD_DESELECT, CMD_MODE_WRITE, CMD_ROW_OPEN, CMD_READ, CMD_WRITE,
        CMD_LONG_CAL, CMD_OTHER
    } cmd_t;
    typedef enum logic [2:0] {
        ST_RESET, ST_INTERNAL_INIT, ST_WAIT_RUN, ST_RUNNING
    } state_t;
endpackage

// ---- dram_init_seq.sv ----
// Device-side power-up sequencing, defaults and command decode of a DRAM.
// Function
// - Reset: half gear-down; addressability, power saving, latencies off.
// - Device initializes internally after reset for INIT_WAIT clock cycles, independent of the run gate.
// - Termination high impedance in reset and until run gate is registered.
// - Device ready for training as soon as the long calibration command is decoded.
// - Four groups of four banks; row open uses 2+2+16 address bits.
// - Eight-fold prefetch: one core word becomes eight pin beats.
// - Bursts of eight or chopped four, A12 selects when enabled.
`timescale 1ns/100ps
module dram_init_seq #(
    parameter int INIT_WAIT = dram_init_pkg::INIT_CYCLES,
    parameter int ROWS = dram_init_pkg::ROW_BITS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register bus
    axi_lite_if.slave bus,
    // Controller pins
    input wire logic runGate,
    input wire logic chipSelect_b,
    input wire logic actPin_b,
    input wire logic rasPin,
    input wire logic casPin,
    input wire logic wePin,
    input wire logic [1:0] groupSelectBits,
    input wire logic [1:0] bankSelectBits,
    input wire logic [17:0] addrPins,
    input wire logic dieTerminationControl,
    input wire logic connectivityTestSelect,
    // Device outputs
    output logic terminationOn,
    output logic terminationHighZ,
    output logic initDone,
    output logic rowOpen,
    output logic [1:0] openGroup,
    output logic [1:0] openBank,
    output logic [ROWS-1:0] openRow,
    output logic burstStart,
    output logic [3:0] burstBeats,
    output logic modeWrite,
    output logic [2:0] modeIndex,
    output logic calStart
);
    initial begin
        if (INIT_WAIT < 1 || ROWS != 16) begin
            $error("dram_init_seq: unsupported parameter values");
        end
    end

    // ========================================================
    // Pin synchronisers
    localparam int NPIN = 30;
    localparam logic [NPIN-1:0] PIN_IDLE = 30'h18000000;
    logic [NPIN-1:0] pinRaw, pinS1_q, pinS2_q;
    assign pinRaw = {runGate, chipSelect_b, actPin_b, rasPin, casPin, wePin,
        groupSelectBits, bankSelectBits, addrPins, dieTerminationControl,
        connectivityTestSelect};
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pinS1_q <= PIN_IDLE;
            pinS2_q <= PIN_IDLE;
        end else begin
            pinS1_q <= pinRaw;
            pinS2_q <= pinS1_q;
        end
    end
    logic sRun, sCs_b, sAct_b, sRas, sCas, sWe, sOdt, sTen;
    logic [1:0] sGrp, sBank;
    logic [17:0] sAddr;
    assign {sRun, sCs_b, sAct_b, sRas, sCas, sWe, sGrp, sBank, sAddr, sOdt,
        sTen} = pinS2_q;

    // ========================================================
    // Command decode
    function automatic dram_init_pkg::cmd_t decode(input logic cs_b,
        input logic act_b, input logic ras, input logic cas, input logic we);
        if (cs_b) begin
            decode = dram_init_pkg::CMD_DESELECT;
        end else if (!act_b) begin
            decode = dram_init_pkg::CMD_ROW_OPEN;
        end else if (!ras && !cas && !we) begin
            decode = dram_init_pkg::CMD_MODE_WRITE;
        end else if (ras && !cas && we) begin
            decode = dram_init_pkg::CMD_READ;
        end else if (ras && !cas && !we) begin
            decode = dram_init_pkg::CMD_WRITE;
        end else if (ras && cas && !we) begin
            decode = dram_init_pkg::CMD_LONG_CAL;
        end else begin
            decode = dram_init_pkg::CMD_OTHER;
        end
    endfunction

    // ========================================================
    // State
    typedef struct packed {
        dram_init_pkg::state_t st;
        logic [31:0] cnt;
        logic runSeen;
        logic prevRun;
        logic [17:0] mode3;
        logic [17:0] mode4;
        logic [17:0] mode5;
        logic [31:0] ctrl;
        logic [2:0] lastCmd;
        logic rowOpen;
        logic [1:0] grp;
        logic [1:0] bank;
        logic [15:0] row;
        logic burst;
        logic [3:0] beats;
        logic mw;
        logic [2:0] mIdx;
        logic cal;
        logic calDone;
    } top_t;
    top_t t_q, t_d;

    logic wrEn, wrOk, rdOk;
    logic [7:0] wrAddr, rdAddr;
    logic [31:0] wrData, rdData;
    logic [3:0] wrStrb;
    dram_init_pkg::cmd_t cmd;
    assign cmd = decode(sCs_b, sAct_b, sRas, sCas, sWe);

    axi_lite_slave u_slave (
        .mclk(mclk),
        .rst_b(rst_b),
        .bus(bus),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(wrOk),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdOk(rdOk)
    );

    always_comb begin
        wrOk = wrAddr == dram_init_pkg::CTRL_OFF;
        rdOk = 1'b1;
        case (rdAddr)
            dram_init_pkg::CTRL_OFF: rdData = t_q.ctrl;
            dram_init_pkg::STATUS_OFF: rdData = {26'h0000000, t_q.calDone,
                t_q.runSeen, t_q.st == dram_init_pkg::ST_RUNNING,
                t_q.st == dram_init_pkg::ST_WAIT_RUN,
                t_q.st == dram_init_pkg::ST_INTERNAL_INIT, sTen};
            dram_init_pkg::MODE3_OFF: rdData = {14'h0000, t_q.mode3};
            dram_init_pkg::MODE4_OFF: rdData = {14'h0000, t_q.mode4};
            dram_init_pkg::MODE5_OFF: rdData = {14'h0000, t_q.mode5};
            dram_init_pkg::LASTCMD_OFF: rdData = {29'h00000000, t_q.lastCmd};
            default: begin
                rdData = 32'h00000000;
                rdOk = 1'b0;
            end
        endcase
    end

    always_comb begin
        t_d = t_q;
        t_d.mw = 1'b0;
        t_d.cal = 1'b0;
        t_d.burst = 1'b0;
        t_d.prevRun = sRun;
        t_d.ctrl[dram_init_pkg::CTRL_RESTART_BIT] = 1'b0;
        if (wrEn && wrOk) begin
            for (int i = 0; i < 4; i++) begin
                if (wrStrb[i]) begin
                    t_d.ctrl[i*8 +: 8] = wrData[i*8 +: 8];
                end
            end
        end
        if (cmd != dram_init_pkg::CMD_DESELECT) begin
            t_d.lastCmd = cmd;
        end
        case (t_q.st)
            dram_init_pkg::ST_RESET: begin
                // Internal init proceeds on a free count, no pin clock needed.
                t_d.st = dram_init_pkg::ST_INTERNAL_INIT;
                t_d.cnt = 32'h00000000;
            end
            dram_init_pkg::ST_INTERNAL_INIT: begin
                t_d.cnt = t_q.cnt + 32'h00000001;
                if (t_q.cnt >= 32'(INIT_WAIT - 1)) begin
                    t_d.st = dram_init_pkg::ST_WAIT_RUN;
                end
            end
            dram_init_pkg::ST_WAIT_RUN: begin
                if (sRun) begin
                    t_d.st = dram_init_pkg::ST_RUNNING;
                    t_d.runSeen = 1'b1;
                end
            end
            dram_init_pkg::ST_RUNNING: begin
                if (cmd == dram_init_pkg::CMD_MODE_WRITE) begin
                    t_d.mw = 1'b1;
                    t_d.mIdx = {sGrp[0], sBank};
                    case ({sGrp[0], sBank})
                        3'h3: t_d.mode3 = sAddr;
                        3'h4: t_d.mode4 = sAddr;
                        3'h5: t_d.mode5 = sAddr;
                        default: t_d.mIdx = {sGrp[0], sBank};
                    endcase
                end
                if (cmd == dram_init_pkg::CMD_LONG_CAL) begin
                    t_d.cal = 1'b1;
                    t_d.calDone = 1'b1;
                end
                if (cmd == dram_init_pkg::CMD_ROW_OPEN) begin
                    t_d.rowOpen = 1'b1;
                    t_d.grp = sGrp;
                    t_d.bank = sBank;
                    t_d.row = sAddr[15:0];
                end
                if (cmd == dram_init_pkg::CMD_READ
                        || cmd == dram_init_pkg::CMD_WRITE) begin
                    t_d.burst = 1'b1;
                    // On-the-fly A12 chooses chop only when enabled.
                    if (t_q.ctrl[dram_init_pkg::CTRL_OTF_BIT]) begin
                        t_d.beats = sAddr[12] ? 4'(dram_init_pkg::PREFETCH)
                            : 4'(dram_init_pkg::CHOP_BEATS);
                    end else begin
                        t_d.beats = t_q.ctrl[dram_init_pkg::CTRL_BC4_BIT]
                            ? 4'(dram_init_pkg::CHOP_BEATS)
                            : 4'(dram_init_pkg::PREFETCH);
                    end
                end
                // A run-gate drop returns to the wait for the run gate, skipping internal init.
                if (t_q.prevRun && !sRun) begin
                    t_d.st = dram_init_pkg::ST_WAIT_RUN;
                    t_d.runSeen = 1'b0;
                    t_d.calDone = 1'b0;
                end
            end
            default: t_d.st = dram_init_pkg::ST_RESET;
        endcase
        if (t_q.ctrl[dram_init_pkg::CTRL_RESTART_BIT]) begin
            t_d.st = dram_init_pkg::ST_RESET;
            t_d.runSeen = 1'b0;
            t_d.calDone = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            t_q <= '0;
            t_q.mode3 <= dram_init_pkg::MODE3_RST;
            t_q.mode4 <= dram_init_pkg::MODE4_RST;
            t_q.mode5 <= dram_init_pkg::MODE5_RST;
            t_q.ctrl <= dram_init_pkg::CTRL_RST;
            t_q.st <= dram_init_pkg::ST_RESET;
        end else begin
            t_q <= t_d;
        end
    end

    // ========================================================
    // Outputs
    assign terminationHighZ = !t_q.runSeen;
    assign terminationOn = t_q.runSeen && sOdt;
    assign initDone = t_q.calDone;
    assign rowOpen = t_q.rowOpen;
    assign openGroup = t_q.grp;
    assign openBank = t_q.bank;
    assign openRow = t_q.row;
    assign burstStart = t_q.burst;
    assign burstBeats = t_q.beats;
    assign modeWrite = t_q.mw;
    assign modeIndex = t_q.mIdx;
    assign calStart = t_q.cal;
endmodule

// ---- dram_init_seq_asserts.sv ----
// Checker of the sequencer's pin-level behaviour.
`timescale 1ns/100ps
module dram_init_seq_chk #(
    parameter int ROWS = dram_init_pkg::ROW_BITS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Controller pins
    input wire logic runGate,
    input wire logic chipSelect_b,
    input wire logic actPin_b,
    input wire logic rasPin,
    input wire logic casPin,
    input wire logic wePin,
    input wire logic [1:0] groupSelectBits,
    input wire logic [1:0] bankSelectBits,
    input wire logic [17:0] addrPins,
    // Device outputs
    input wire logic terminationOn,
    input wire logic terminationHighZ,
    input wire logic initDone,
    input wire logic rowOpen,
    input wire logic [1:0] openGroup,
    input wire logic [1:0] openBank,
    input wire logic [ROWS-1:0] openRow,
    input wire logic burstStart,
    input wire logic [3:0] burstBeats,
    input wire logic modeWrite,
    input wire logic [2:0] modeIndex,
    input wire logic calStart,
    // Read channel
    input wire logic rvalid,
    input wire logic rready
);
    // ====
    // Command decode
    logic [3:0] pins;
    logic isMode;
    logic isCal;
    logic isRow;
    logic isRw;
    logic [2:0] idxQ;
    logic [1:0] grpQ;
    logic [1:0] bankQ;
    logic [ROWS-1:0] rowQ;
    assign pins = {chipSelect_b, rasPin, casPin, wePin};
    assign isMode = actPin_b && pins == 4'h0;
    assign isCal = actPin_b && pins == 4'h6;
    assign isRw = actPin_b && (pins == 4'h5 || pins == 4'h4);
    assign isRow = !chipSelect_b && !actPin_b;
    // Fields are kept so the answer can be judged a few cycles later.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {idxQ, grpQ, bankQ, rowQ} <= '0;
        end else begin
            if (isMode) idxQ <= {groupSelectBits[0], bankSelectBits};
            if (isRow) {grpQ, bankQ, rowQ} <=
                {groupSelectBits, bankSelectBits, addrPins[ROWS-1:0]};
        end
    end
    // ====
    // Properties
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_modeAns;
        ##[2:5] (modeWrite && modeIndex == idxQ);
    endsequence
    sequence s_calAns;
        ##[2:5] calStart ##1 !calStart;
    endsequence
    property p_hizHeld;
        terminationHighZ && !runGate |=> terminationHighZ;
    endproperty
    a_hizHeld: assert property (p_hizHeld)
        else $error("termination left high impedance without run gate");
    property p_hizRelease;
        $fell(terminationHighZ) |-> $past(runGate, 2);
    endproperty
    a_hizRelease: assert property (p_hizRelease)
        else $error("termination released before run gate registered");
    property p_termOff;
        terminationHighZ |-> !terminationOn;
    endproperty
    a_termOff: assert property (p_termOff)
        else $error("termination active while high impedance");
    property p_modeDecode;
        isMode |-> s_modeAns;
    endproperty
    a_modeDecode: assert property (p_modeDecode)
        else $error("mode write not reported with its index");
    property p_calPulse;
        isCal |-> s_calAns;
    endproperty
    a_calPulse: assert property (p_calPulse)
        else $error("calibration start pulse missing");
    property p_calDone;
        isCal |-> ##[2:6] initDone ##1 initDone;
    endproperty
    a_calDone: assert property (p_calDone)
        else $error("ready flag not set after calibration");
    property p_rowOpen;
        isRow |-> ##[2:5] (rowOpen && openGroup == grpQ
            && openBank == bankQ && openRow == rowQ);
    endproperty
    a_rowOpen: assert property (p_rowOpen)
        else $error("row open fields do not follow the pins");
    property p_burstStart;
        isRw |-> ##[2:5] burstStart;
    endproperty
    a_burstStart: assert property (p_burstStart)
        else $error("no burst after read or write");
    property p_burstLen;
        burstStart |-> burstBeats == 4'h8 || burstBeats == 4'h4;
    endproperty
    a_burstLen: assert property (p_burstLen)
        else $error("burst length neither eight nor four");
    property p_rTaken;
        rvalid && rready |=> !rvalid;
    endproperty
    a_rTaken: assert property (p_rTaken)
        else $error("read answer held after it was taken");
endmodule
bind dram_init_seq dram_init_seq_chk #(.ROWS(ROWS)) u_chk (
    .mclk(mclk), .rst_b(rst_b), .runGate(runGate),
    .chipSelect_b(chipSelect_b), .actPin_b(actPin_b), .rasPin(rasPin),
    .casPin(casPin), .wePin(wePin), .groupSelectBits(groupSelectBits),
    .bankSelectBits(bankSelectBits), .addrPins(addrPins),
    .terminationOn(terminationOn), .terminationHighZ(terminationHighZ),
    .initDone(initDone), .rowOpen(rowOpen), .openGroup(openGroup),
    .openBank(openBank), .openRow(openRow), .burstStart(burstStart),
    .burstBeats(burstBeats), .modeWrite(modeWrite),
    .modeIndex(modeIndex), .calStart(calStart), .rvalid(bus.rvalid),
    .rready(bus.rready));

// ---- dram_init_seq_tb.sv ----
// Self-checking bench of the power-up sequencer.
`timescale 1ns/100ps
module dram_init_seq_tb;
    localparam int INIT_WAIT = 20;
    logic mclk;
    logic rst_b;
    logic runGate, chipSelect_b, actPin_b, rasPin, casPin, wePin;
    logic [1:0] groupSelectBits;
    logic [1:0] bankSelectBits;
    logic [17:0] addrPins;
    logic dieTerminationControl, connectivityTestSelect;
    logic terminationOn, terminationHighZ, initDone, rowOpen;
    logic [1:0] openGroup;
    logic [1:0] openBank;
    logic [15:0] openRow;
    logic burstStart, modeWrite, calStart;
    logic [3:0] burstBeats;
    logic [3:0] beatsSeen;
    logic [2:0] modeIndex;
    logic [2:0] modeSeen[$];
    logic [2:0] order[7] = '{3, 6, 5, 4, 2, 1, 0};
    logic [31:0] ctrlTab[4] = '{32'h1, 32'h1, 32'h0, 32'h2};
    logic [17:0] adrTab[4] = '{18'h01000, 18'h0, 18'h0, 18'h01000};
    logic [3:0] beatTab[4] = '{4'h8, 4'h4, 4'h8, 4'h4};
    int miscompares = 0;
    int testsRun = 0;
    axi_lite_if bus();
    dram_init_seq #(.INIT_WAIT(INIT_WAIT)) u_dut (.mclk(mclk), .rst_b(rst_b),
        .bus(bus.slave), .runGate(runGate), .chipSelect_b(chipSelect_b),
        .actPin_b(actPin_b), .rasPin(rasPin), .casPin(casPin), .wePin(wePin),
        .groupSelectBits(groupSelectBits), .bankSelectBits(bankSelectBits),
        .addrPins(addrPins), .dieTerminationControl(dieTerminationControl),
        .connectivityTestSelect(connectivityTestSelect),
        .terminationOn(terminationOn), .terminationHighZ(terminationHighZ),
        .initDone(initDone), .rowOpen(rowOpen), .openGroup(openGroup),
        .openBank(openBank), .openRow(openRow), .burstStart(burstStart),
        .burstBeats(burstBeats), .modeWrite(modeWrite),
        .modeIndex(modeIndex), .calStart(calStart));
    dram_ctl_model u_ctl (.mclk(mclk), .runGate(runGate),
        .chipSelect_b(chipSelect_b), .actPin_b(actPin_b), .rasPin(rasPin),
        .casPin(casPin), .wePin(wePin), .groupSelectBits(groupSelectBits),
        .bankSelectBits(bankSelectBits), .addrPins(addrPins),
        .dieTerminationControl(dieTerminationControl),
        .connectivityTestSelect(connectivityTestSelect));
    // ====
    // Clock, monitor and watchdog
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Pulses stand one cycle, so they are caught here as they pass.
    always @(posedge mclk) begin
        if (modeWrite === 1'b1) modeSeen.push_back(modeIndex);
        if (burstStart === 1'b1) beatsSeen <= burstBeats;
    end
    initial begin
        repeat (4000) @(posedge mclk);
        miscompares++;
        summarize();
    end
    // ====
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge mclk);
        {bus.awaddr, bus.wdata, bus.wstrb} <= {a, d, 4'hf};
        {bus.awvalid, bus.wvalid, bus.bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (bus.awready) bus.awvalid <= 1'b0;
            if (bus.wready) bus.wvalid <= 1'b0;
        end while (!bus.bvalid);
        bus.bready <= 1'b0;
        chk(32'(bus.bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        @(posedge mclk);
        bus.araddr <= a;
        {bus.arvalid, bus.rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (bus.arready) bus.arvalid <= 1'b0;
        end while (!bus.rvalid);
        bus.rready <= 1'b0;
        chk(bus.rdata, ed);
        chk(32'(bus.rresp), 32'(er));
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ====
    // Tests
    initial begin
        rst_b = 1'b0;
        {bus.awaddr, bus.awvalid, bus.wdata, bus.wstrb, bus.wvalid} = '0;
        {bus.bready, bus.araddr, bus.arvalid, bus.rready} = '0;
        repeat (3) @(posedge mclk);
        chk(32'(terminationHighZ), 32'h1);
        rst_b <= 1'b1;
        rd(dram_init_pkg::STATUS_OFF, 32'h2, 2'h0);
        rd(dram_init_pkg::MODE3_OFF, 32'(dram_init_pkg::MODE3_RST), 2'h0);
        rd(dram_init_pkg::MODE4_OFF, 32'(dram_init_pkg::MODE4_RST), 2'h0);
        rd(dram_init_pkg::MODE5_OFF, 32'(dram_init_pkg::MODE5_RST), 2'h0);
        rd(dram_init_pkg::CTRL_OFF, dram_init_pkg::CTRL_RST, 2'h0);
        rd(8'h1c, 32'h0, 2'h2);
        wr(dram_init_pkg::MODE3_OFF, 32'hffffffff, 2'h2);
        rd(dram_init_pkg::MODE3_OFF, 32'h8, 2'h0);
        repeat (10) @(posedge mclk);
        rd(dram_init_pkg::STATUS_OFF, 32'h4, 2'h0);
        chk({terminationOn, terminationHighZ}, 32'h1);
        u_ctl.power_up(INIT_WAIT);
        repeat (8) @(posedge mclk);
        chk(modeSeen.size(), 32'd7);
        foreach (order[i]) chk(32'(modeSeen[i]), 32'(order[i]));
        chk({calStart, initDone, terminationOn, terminationHighZ}, 32'h6);
        rd(dram_init_pkg::STATUS_OFF, 32'h38, 2'h0);
        rd(dram_init_pkg::LASTCMD_OFF, 32'(dram_init_pkg::CMD_LONG_CAL), 2'h0);
        u_ctl.issue(4'h0, 2'h3, 2'h2, 18'h0ffff);
        repeat (6) @(posedge mclk);
        chk({rowOpen, openGroup, openBank, openRow}, 32'h1effff);
        u_ctl.issue(4'h7, 2'h0, 2'h1, 18'h30001);
        repeat (6) @(posedge mclk);
        chk({rowOpen, openGroup, openBank, openRow}, 32'h110001);
        for (int i = 0; i < 4; i++) begin
            wr(dram_init_pkg::CTRL_OFF, ctrlTab[i], 2'h0);
            beatsSeen = 4'h0;
            u_ctl.issue(i[0] ? 4'hc : 4'hd, 2'h1, 2'h2, adrTab[i]);
            repeat (6) @(posedge mclk);
            chk(32'(beatsSeen), 32'(beatTab[i]));
        end
        wr(dram_init_pkg::CTRL_OFF, 32'h4, 2'h0);
        rd(dram_init_pkg::STATUS_OFF, 32'h2, 2'h0);
        u_ctl.drop_gate();
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({rowOpen, initDone, terminationHighZ}, 32'h1);
        rst_b <= 1'b1;
        rd(dram_init_pkg::CTRL_OFF, dram_init_pkg::CTRL_RST, 2'h0);
        rd(dram_init_pkg::MODE3_OFF, 32'h8, 2'h0);
        summarize();
    end
endmodule
